/* File: mism_pkg.sv */
// Package for the motor input select and mix block
package mism_pkg;
	localparam int ADC_W = 12;
	localparam int RC_W = 16;
	localparam int SPD_W = 16;
	localparam logic signed [15:0] SCALE_FULL = 16'sh0C80;
	localparam logic signed [15:0] SWITCH_THRESH = 16'sh0640;
	localparam logic [11:0] ADC_MAX = 12'hFFF;
	localparam logic [11:0] POT_LOW_FAULT = 12'h008;
	localparam logic [11:0] POT_HIGH_FAULT = 12'hFF7;
	localparam real CONV_PERIOD_US = 10.0;
	localparam real CLK_MHZ = 50.0;
	localparam int CONV_CYCLES = int'(CONV_PERIOD_US * CLK_MHZ);
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_CH_CFG = 4'h1;
	localparam logic [3:0] ADDR_SER_SPEED = 4'h2;
	localparam logic [3:0] ADDR_TARGET = 4'h3;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_RAW_A1 = 4'h5;
	localparam logic [3:0] ADDR_RAW_A2 = 4'h6;
	localparam logic [3:0] ADDR_RAW_P1 = 4'h7;
	localparam logic [3:0] ADDR_RAW_P2 = 4'h8;
	localparam logic [3:0] ADDR_SCL_A1 = 4'h9;
	localparam logic [3:0] ADDR_SCL_A2 = 4'hA;
	localparam logic [3:0] ADDR_SCL_P1 = 4'hB;
	localparam logic [3:0] ADDR_SCL_P2 = 4'hC;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CH_CFG_RESET = 32'h0000_0000;
	typedef enum logic [1:0] {
		MISM_IN_SERIAL = 2'h0,
		MISM_IN_ANALOG = 2'h1,
		MISM_IN_PULSE = 2'h3
	} mism_in_mode_t;
	typedef enum logic [1:0] {
		MISM_MIX_NONE = 2'h0,
		MISM_MIX_LEFT = 2'h1,
		MISM_MIX_RIGHT = 2'h2
	} mism_mix_t;
	typedef enum logic [1:0] {
		MISM_USE_NONE = 2'h0,
		MISM_USE_FWD_LIMIT = 2'h1,
		MISM_USE_REV_LIMIT = 2'h2,
		MISM_USE_KILL = 2'h3
	} mism_alt_use_t;
	typedef enum logic [1:0] {
		MISM_ADC_IDLE = 2'h0,
		MISM_ADC_START = 2'h1,
		MISM_ADC_WAIT = 2'h3,
		MISM_ADC_STORE = 2'h2
	} mism_adc_state_t;
endpackage

/* File: mism_scaler.sv */
// Maps a raw channel reading onto the signed speed scale
`timescale 1ns/10ps
`default_nettype none
module mism_scaler
	import mism_pkg::*;
#(
	parameter int RAW_W = 16
) (
	input  wire logic [RAW_W-1:0] raw,
	input  wire logic [RAW_W-1:0] err_min,
	input  wire logic [RAW_W-1:0] err_max,
	input  wire logic [RAW_W-1:0] neutral,
	input  wire logic [RAW_W-1:0] span,
	input  wire logic             invert,
	output logic signed [15:0]    scaled,
	output logic                  valid
);
	logic signed [RAW_W+1:0] delta;
	logic signed [RAW_W+14:0] prod;
	logic signed [RAW_W+14:0] quot;
	logic signed [15:0]       sat;
	always_comb begin
		valid = (raw >= err_min) && (raw <= err_max);
		delta = $signed({2'b00, raw}) - $signed({2'b00, neutral});
		prod = (RAW_W+15)'(delta) * (RAW_W+15)'(SCALE_FULL);
		if (span == '0) begin
			quot = '0;
		end else begin
			quot = prod / $signed({15'd0, span});
		end
		// Clamp to full scale, zero when invalid
		if (quot > (RAW_W+15)'(SCALE_FULL)) begin
			sat = SCALE_FULL;
		end else if (quot < -(RAW_W+15)'(SCALE_FULL)) begin
			sat = -SCALE_FULL;
		end else begin
			sat = quot[15:0];
		end
		scaled = !valid ? 16'sh0000 : (invert ? -sat : sat);
	end
endmodule
`default_nettype wire

/* File: mism_top.sv */
// Motor input selection, mixing and limit switch logic
// Behaviour
// R1 - Analog channels convert to twelve bits
// R2 - No mixing: speed from channel one only
// R3 - Mixing: channel one throttle, two steering
// R4 - Left mixing adds throttle and steering
// R5 - Right mixing subtracts steering from throttle
// R6 - Spare channel may be limit/kill switch
// R7 - Switch active above half full forward
// R8 - Detect disconnected pot on powered channels
// R9 - Option disables pot disconnection detection
// R10 - Configurable pull-up on each analog line
// R11 - Wiring fault gives error or active switch
// R12 - Serial mode uses serial speed commands
// R13 - Serial mode zeroes speed on error
// R14 - Reset selects serial input mode
// R15 - Analog mode uses analog channel(s)
// R16 - Pulse mode uses pulse channel(s)
// R17 - All channels always measured and readable
// R18 - Mixed result saturates at full scale
// R19 - Valid readings map to signed scale
// R20 - Switch active when scaled above 1600
// R21 - Raw analog zero to 4095
// R22 - Switch channel invalid raises error
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module mism_top
	import mism_pkg::*;
#(
	parameter int CONV_CNT = CONV_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic [3:0]        addr,
	input  wire logic [31:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic [31:0]            rdata,
	output logic                   adc_start,
	output logic [1:0]             adc_sel,
	input  wire logic              adc_done,
	input  wire logic [ADC_W-1:0]  adc_data,
	input  wire logic [RC_W-1:0]   pulse_width_first,
	input  wire logic [RC_W-1:0]   pulse_width_second,
	input  wire logic              pulse_valid_first,
	input  wire logic              pulse_valid_second,
	input  wire logic              ext_error,
	output logic [1:0]             pullup_en,
	output logic signed [SPD_W-1:0] target_speed,
	output logic                   fwd_limit,
	output logic                   rev_limit,
	output logic                   kill_active,
	output logic                   chan_error,
	output logic                   pot_disconnect
);
	// Channel index 0 and 1 analog, 2 and 3 pulse
	logic [31:0]            ctrl_reg, ctrl_next;
	logic [31:0]            cfg_reg, cfg_next;
	logic signed [15:0]     ser_reg, ser_next;
	logic [ADC_W-1:0]       araw_reg [2], araw_next [2];
	logic [1:0]             dis_reg, dis_next;
	logic [31:0]            rdata_next;
	mism_adc_state_t        st_reg, st_next;
	logic [15:0]            cnt_reg, cnt_next;
	logic                   chn_reg, chn_next;
	logic signed [15:0]     spd_reg, spd_next;
	logic [4:0]             flg_reg, flg_next;
	logic [1:0]             pu_reg;
	logic [RC_W-1:0]        raw [4];
	logic signed [15:0]     scl [4];
	logic [3:0]             vld;
	logic [RC_W-1:0]        cal_emin [4], cal_emax [4], cal_neu [4], cal_span [4];
	mism_in_mode_t          mode;
	mism_mix_t              mix;
	logic                   ign_pot;
	logic [1:0]             ctl_pu;
	logic [1:0]             pv_s1, pv_s2;
	logic [RC_W-1:0]        pw1_s1, pw1_s2, pw2_s1, pw2_s2;
	logic                   done_s1, done_s2;
	logic [ADC_W-1:0]       adat_s1, adat_s2;

	// Decode a channel's alternate use from the channel config word
	function automatic mism_alt_use_t alt_use(input logic [31:0] c, input int i);
		alt_use = mism_alt_use_t'(c[2*i +: 2]);
	endfunction

	assign mode = mism_in_mode_t'(ctrl_reg[1:0]);
	assign mix = mism_mix_t'(ctrl_reg[3:2]);
	assign ign_pot = ctrl_reg[4];
	assign ctl_pu = ctrl_reg[6:5];

	// Pin level inputs cross two flops
	always_ff @(posedge clk) begin
		pv_s1 <= {pulse_valid_second, pulse_valid_first};
		pv_s2 <= pv_s1;
		pw1_s1 <= pulse_width_first;
		pw1_s2 <= pw1_s1;
		pw2_s1 <= pulse_width_second;
		pw2_s2 <= pw2_s1;
		done_s1 <= adc_done;
		done_s2 <= done_s1;
		adat_s1 <= adc_data;
		adat_s2 <= adat_s1;
	end

	// Fixed calibration: analog uses full 12-bit span, pulse 4000..8000 quarter-us
	assign raw[0] = RC_W'(araw_reg[0]);
	assign raw[1] = RC_W'(araw_reg[1]);
	assign raw[2] = pw1_s2;
	assign raw[3] = pw2_s2;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ch
			assign cal_emin[gi] = (gi < 2) ? 16'h0000 : 16'h0BB8;
			assign cal_emax[gi] = (gi < 2) ? 16'h0FFF : 16'h2EE0;
			assign cal_neu[gi] = (gi < 2) ? 16'h0800 : 16'h1770;
			assign cal_span[gi] = (gi < 2) ? 16'h07F0 : 16'h07D0;
			// R19 signed scaling
			mism_scaler #(.RAW_W(RC_W)) u_scl (
				.raw     (raw[gi]),
				.err_min (cal_emin[gi]),
				.err_max (cal_emax[gi]),
				.neutral (cal_neu[gi]),
				.span    (cal_span[gi]),
				.invert  (cfg_reg[8+gi]),
				.scaled  (scl[gi]),
				.valid   (vld[gi])
			);
		end
	endgenerate

	// Converter sequencer
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		chn_next = chn_reg;
		araw_next = araw_reg;
		dis_next = dis_reg;
		case (st_reg)
			MISM_ADC_IDLE: begin
				cnt_next = cnt_reg + 16'h0001;
				if (cnt_reg >= 16'(CONV_CNT - 1)) begin
					cnt_next = '0;
					st_next = MISM_ADC_START;
				end
			end
			MISM_ADC_START: st_next = MISM_ADC_WAIT;
			MISM_ADC_WAIT: if (done_s2) st_next = MISM_ADC_STORE;
			MISM_ADC_STORE: begin
				// R1 R21 twelve-bit reading
				araw_next[chn_reg] = adat_s2;
				// R8 R9 rail reading means pot disconnected
				dis_next[chn_reg] = !ign_pot && !ctl_pu[chn_reg] &&
					(adat_s2 <= POT_LOW_FAULT || adat_s2 >= POT_HIGH_FAULT);
				chn_next = !chn_reg;
				st_next = MISM_ADC_IDLE;
			end
			default: st_next = MISM_ADC_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= MISM_ADC_IDLE;
			cnt_reg <= '0;
			chn_reg <= 1'b0;
			araw_reg[0] <= '0;
			araw_reg[1] <= '0;
			dis_reg <= '0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			chn_reg <= chn_next;
			araw_reg <= araw_next;
			dis_reg <= dis_next;
		end
	end

	// Speed selection, mixing and switches
	always_comb begin
		logic signed [16:0] mixv;
		logic signed [15:0] s1, s2;
		logic               any_err, fwd, rev, kil, req_bad, spd_bad;
		int                 base;
		mixv = '0;
		any_err = 1'b0;
		fwd = 1'b0;
		rev = 1'b0;
		kil = 1'b0;
		req_bad = 1'b0;
		spd_bad = 1'b0;
		base = (mode == MISM_IN_PULSE) ? 2 : 0;
		s1 = scl[base];
		s2 = scl[base+1];
		for (int i = 0; i < 4; i++) begin
			// R6 R7 R20 spare channel as switch above half scale
			if (alt_use(cfg_reg, i) != MISM_USE_NONE) begin
				// R22 R11 switch channel must stay valid
				if (!vld[i] || (i < 2 && dis_reg[i])) begin
					req_bad = 1'b1;
				end else if (scl[i] > SWITCH_THRESH) begin
					fwd = fwd | (alt_use(cfg_reg, i) == MISM_USE_FWD_LIMIT);
					rev = rev | (alt_use(cfg_reg, i) == MISM_USE_REV_LIMIT);
					kil = kil | (alt_use(cfg_reg, i) == MISM_USE_KILL);
				end
			end
		end
		if (mode != MISM_IN_SERIAL) begin
			spd_bad = !vld[base] || (base == 0 && dis_reg[0]);
			if (mix != MISM_MIX_NONE) begin
				spd_bad = spd_bad || !vld[base+1] || (base == 0 && dis_reg[1]);
			end
		end
		case (mix)
			// R3 R4 left adds
			MISM_MIX_LEFT: mixv = 17'(s1) + 17'(s2);
			// R5 right subtracts
			MISM_MIX_RIGHT: mixv = 17'(s1) - 17'(s2);
			// R2 channel one only
			default: mixv = 17'(s1);
		endcase
		any_err = ext_error || req_bad || spd_bad || kil;
		case (mode)
			// R12 R13 serial speed, zero on error
			MISM_IN_SERIAL: spd_next = any_err ? 16'sh0000 : ser_reg;
			// R15 R16 R18 channel speed saturated
			MISM_IN_ANALOG, MISM_IN_PULSE: begin
				if (any_err) spd_next = 16'sh0000;
				else if (mixv > 17'(SCALE_FULL)) spd_next = SCALE_FULL;
				else if (mixv < -17'(SCALE_FULL)) spd_next = -SCALE_FULL;
				else spd_next = mixv[15:0];
			end
			default: spd_next = 16'sh0000;
		endcase
		if ((fwd && spd_next > 0) || (rev && spd_next < 0)) begin
			spd_next = 16'sh0000;
		end
		flg_next = {|dis_reg, req_bad || spd_bad, kil, rev, fwd};
	end

	// Register bus
	always_comb begin
		ctrl_next = ctrl_reg;
		cfg_next = cfg_reg;
		ser_next = ser_reg;
		rdata_next = 32'h0000_0000;
		if (wr) begin
			case (addr)
				ADDR_CTRL: ctrl_next = wdata;
				ADDR_CH_CFG: cfg_next = wdata;
				ADDR_SER_SPEED: ser_next = wdata[15:0];
				default: ;
			endcase
		end
		if (rd) begin
			// R17 all channels readable in every mode
			case (addr)
				ADDR_CTRL: rdata_next = {25'd0, ctrl_reg[6:0]};
				ADDR_CH_CFG: rdata_next = {20'd0, cfg_reg[11:0]};
				ADDR_SER_SPEED: rdata_next = {{16{ser_reg[15]}}, ser_reg};
				ADDR_TARGET: rdata_next = {{16{spd_reg[15]}}, spd_reg};
				ADDR_STATUS: rdata_next = {23'd0, vld, flg_reg};
				ADDR_RAW_A1: rdata_next = {20'd0, araw_reg[0]};
				ADDR_RAW_A2: rdata_next = {20'd0, araw_reg[1]};
				ADDR_RAW_P1: rdata_next = {16'd0, raw[2]};
				ADDR_RAW_P2: rdata_next = {16'd0, raw[3]};
				ADDR_SCL_A1: rdata_next = {{16{scl[0][15]}}, scl[0]};
				ADDR_SCL_A2: rdata_next = {{16{scl[1][15]}}, scl[1]};
				ADDR_SCL_P1: rdata_next = {{16{scl[2][15]}}, scl[2]};
				ADDR_SCL_P2: rdata_next = {{16{scl[3][15]}}, scl[3]};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			// R14 serial mode after reset
			ctrl_reg <= CTRL_RESET;
			cfg_reg <= CH_CFG_RESET;
			ser_reg <= 16'sh0000;
			rdata <= 32'h0000_0000;
			spd_reg <= 16'sh0000;
			flg_reg <= '0;
			pu_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			cfg_reg <= cfg_next;
			ser_reg <= ser_next;
			rdata <= rdata_next;
			spd_reg <= spd_next;
			flg_reg <= flg_next;
			// R10 pull-up enables
			pu_reg <= ctl_pu;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			adc_start <= 1'b0;
			adc_sel <= 2'h0;
		end else begin
			adc_start <= (st_next == MISM_ADC_START);
			adc_sel <= {1'b0, chn_next};
		end
	end

	assign pullup_en = pu_reg;
	assign target_speed = spd_reg;
	assign fwd_limit = flg_reg[0];
	assign rev_limit = flg_reg[1];
	assign kill_active = flg_reg[2];
	assign chan_error = flg_reg[3];
	assign pot_disconnect = flg_reg[4];
endmodule
`default_nettype wire

/* File: mism_pot_model.sv */
// Converter and potentiometer model at the analog side of the block
`timescale 1ns/10ps
`default_nettype none
module mism_pot_model
	import mism_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             adc_start,
	input  wire logic [1:0]       adc_sel,
	input  wire logic             slow,
	input  wire logic [ADC_W-1:0] val_first,
	input  wire logic [ADC_W-1:0] val_second,
	output logic                  adc_done,
	output logic [ADC_W-1:0]      adc_data
);
	int               cnt    = 0;
	logic             ch     = 1'b0;
	logic             done_r = 1'b0;
	logic [ADC_W-1:0] data_r = 12'h000;
	assign adc_done = done_r;
	assign adc_data = data_r;
	always @(posedge clk) begin
		if (adc_start) begin
			ch <= adc_sel[0];
			cnt <= slow ? 14 : 5;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
		if (cnt >= 1 && cnt <= 4) begin
			done_r <= 1'b1;
			data_r <= ch ? val_second : val_first;
		end else begin
			done_r <= 1'b0;
			// Bus released: data keeps changing
			data_r <= ~data_r;
		end
	end
endmodule
`default_nettype wire

/* File: mism_top_checker.sv */
// Assertions on the ports of the motor input select and mix block
`timescale 1ns/10ps
`default_nettype none
module mism_top_checker
	import mism_pkg::*;
(
	input wire logic              clk,
	input wire logic              srst,
	input wire logic [3:0]        addr,
	input wire logic              rd,
	input wire logic [31:0]       rdata,
	input wire logic              adc_start,
	input wire logic signed [SPD_W-1:0] target_speed,
	input wire logic              fwd_limit,
	input wire logic              rev_limit,
	input wire logic              kill_active,
	input wire logic              chan_error
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_held(logic b);
		b ##1 b;
	endsequence
	a_speed_range: assert property (target_speed <= SCALE_FULL && target_speed >= -SCALE_FULL)
		else $error("target speed out of range");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
		else $error("read data not zero outside a read");
	a_target_read: assert property (rd && addr == ADDR_TARGET |=>
		rdata == {{16{$past(target_speed[15])}}, $past(target_speed)})
		else $error("target read mismatch");
	a_kill_stop: assert property (s_held(kill_active) |-> target_speed == 16'sh0000)
		else $error("speed not zero under kill");
	a_err_stop: assert property (s_held(chan_error) |-> target_speed == 16'sh0000)
		else $error("speed not zero under channel error");
	a_fwd_stop: assert property (s_held(fwd_limit) |-> target_speed <= 16'sh0000)
		else $error("forward speed under forward limit");
	a_rev_stop: assert property (s_held(rev_limit) |-> target_speed >= 16'sh0000)
		else $error("reverse speed under reverse limit");
	a_start_pulse: assert property (adc_start |=> !adc_start)
		else $error("conversion start longer than one cycle");
endmodule
bind mism_top mism_top_checker mism_top_checker_i (.clk(clk), .srst(srst), .addr(addr),
	.rd(rd), .rdata(rdata), .adc_start(adc_start), .target_speed(target_speed),
	.fwd_limit(fwd_limit), .rev_limit(rev_limit), .kill_active(kill_active),
	.chan_error(chan_error));
`default_nettype wire

/* File: tb_mism_top.sv */
// Testbench for the motor input select and mix block
`timescale 1ns/10ps
`default_nettype none
module tb_mism_top
	import mism_pkg::*;
;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        ext_error = 1'b0;
	logic        slow = 1'b0;
	logic [15:0] pw1 = 16'h1770;
	logic [15:0] pw2 = 16'h1770;
	logic [11:0] va1 = 12'h800;
	logic [11:0] va2 = 12'h800;
	logic [31:0] rdata;
	logic        adc_start, adc_done, fwd_limit, rev_limit, kill_active, chan_error, pot_disc;
	logic [1:0]  adc_sel, pullup_en;
	logic [11:0] adc_data;
	logic signed [15:0] target_speed;
	int          n_mismatch = 0;
	int          n_tests = 0;
	localparam logic [15:0] P1 [6] = '{16'h1F40, 16'h1770, 16'h1770, 16'h1F40, 16'h0FA0, 16'h0FA0};
	localparam logic [15:0] P2 [6] = '{16'h0FA0, 16'h1F40, 16'h1F40, 16'h1F40, 16'h1F40, 16'h1F40};
	localparam logic [1:0]  MX [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1};
	localparam logic [31:0] EX [6] = '{32'h0C80, 32'h0C80, 32'hFFFF_F380, 32'h0C80,
		32'hFFFF_F380, 32'h0};
	always #10 clk = ~clk;
	mism_top #(.CONV_CNT(4)) mism_top_i (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .adc_start(adc_start), .adc_sel(adc_sel),
		.adc_done(adc_done), .adc_data(adc_data), .pulse_width_first(pw1),
		.pulse_width_second(pw2), .pulse_valid_first(1'b1), .pulse_valid_second(1'b1),
		.ext_error(ext_error), .pullup_en(pullup_en), .target_speed(target_speed),
		.fwd_limit(fwd_limit), .rev_limit(rev_limit), .kill_active(kill_active),
		.chan_error(chan_error), .pot_disconnect(pot_disc));
	mism_pot_model mism_pot_model_i (.clk(clk), .adc_start(adc_start), .adc_sel(adc_sel),
		.slow(slow), .val_first(va1), .val_second(va2), .adc_done(adc_done),
		.adc_data(adc_data));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input string n, input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(n, rdata, e);
	endtask
	// Covers six slow conversions and the pin synchronisers
	task automatic ts(input logic [31:0] e);
		repeat (120) @(posedge clk);
		chk("target", {{16{target_speed[15]}}, target_speed}, e);
	endtask
	task automatic test_done;
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#400000;
		n_mismatch++;
		test_done;
	end
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		rreg("ctrl", ADDR_CTRL, CTRL_RESET);
		rreg("chcfg", ADDR_CH_CFG, CH_CFG_RESET);
		rreg("unmapped", 4'hF, 32'h0);
		wreg(ADDR_SER_SPEED, 32'h0000_03E8);
		ts(32'h0000_03E8);
		rreg("target", ADDR_TARGET, 32'h0000_03E8);
		ext_error <= 1'b1;
		ts(32'h0);
		ext_error <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			pw1 <= P1[i];
			pw2 <= P2[i];
			wreg(ADDR_CTRL, {28'h0, MX[i], 2'h3});
			ts(EX[i]);
		end
		va1 <= 12'hFF0;
		wreg(ADDR_CTRL, 32'h1);
		ts(32'h0C80);
		rreg("raw_a1", ADDR_RAW_A1, 32'h0000_0FF0);
		rreg("raw_p1", ADDR_RAW_P1, 32'h0000_0FA0);
		slow <= 1'b1;
		va2 <= 12'hFFA;
		ts(32'h0C80);
		chk("pot", pot_disc, 32'h1);
		wreg(ADDR_CTRL, 32'h11);
		ts(32'h0C80);
		chk("pot", pot_disc, 32'h0);
		wreg(ADDR_CTRL, 32'h61);
		ts(32'h0C80);
		chk("pullup", pullup_en, 32'h3);
		chk("pot", pot_disc, 32'h0);
		wreg(ADDR_CH_CFG, 32'hC);
		wreg(ADDR_CTRL, 32'h1);
		ts(32'h0);
		chk("pot", pot_disc, 32'h1);
		va2 <= 12'hFF0;
		ts(32'h0);
		chk("kill", kill_active, 32'h1);
		va2 <= 12'h800;
		ts(32'h0C80);
		chk("kill", kill_active, 32'h0);
		wreg(ADDR_CH_CFG, 32'hC0);
		wreg(ADDR_CTRL, 32'h0);
		pw2 <= 16'h1B58;
		ts(32'h0000_03E8);
		chk("kill", kill_active, 32'h0);
		pw2 <= 16'h1B62;
		ts(32'h0);
		chk("kill", kill_active, 32'h1);
		pw2 <= 16'h07D0;
		ts(32'h0);
		chk("chan_err", chan_error, 32'h1);
		wreg(ADDR_CH_CFG, 32'h40);
		pw2 <= 16'h1F40;
		ts(32'h0);
		chk("fwd", fwd_limit, 32'h1);
		wreg(ADDR_SER_SPEED, 32'hFFFF_FC18);
		ts(32'hFFFF_FC18);
		wreg(ADDR_CH_CFG, 32'h80);
		ts(32'h0);
		chk("rev", rev_limit, 32'h1);
		rreg("status", ADDR_STATUS, 32'h0000_01E2);
		rreg("raw_a2", ADDR_RAW_A2, 32'h0000_0800);
		rreg("scl_p2", ADDR_SCL_P2, 32'h0000_0C80);
		wreg(ADDR_CH_CFG, 32'h800);
		rreg("scl_p2_inv", ADDR_SCL_P2, 32'hFFFF_F380);
		// Second reset in mid-run
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		chk("target_rst", {{16{target_speed[15]}}, target_speed}, 32'h0);
		chk("rev_rst", rev_limit, 32'h0);
		rreg("ctrl_rst", ADDR_CTRL, CTRL_RESET);
		rreg("chcfg_rst", ADDR_CH_CFG, CH_CFG_RESET);
		test_done;
	end
endmodule
`default_nettype wire
